// >>> hw/shsf_map.vh
// Register map and constants for the serial host status-flag block.
// Assumes inclusion by the design files only; definitions only.
`ifndef SHSF_MAP_VH
`define SHSF_MAP_VH
// Register addresses (plain port, word index)
`define SHSF_ADDR_CTRL     4'h0
`define SHSF_ADDR_STATUS   4'h1
`define SHSF_ADDR_TXHOLD   4'h2
`define SHSF_ADDR_RXQUEUE  4'h3
`define SHSF_ADDR_VECTOR   4'h4
// Control register fields
`define SHSF_CTL_ENABLE    0
`define SHSF_CTL_I2C       1
`define SHSF_CTL_MASTER    2
`define SHSF_CTL_CLOCK_PHASE_SELECT      3
`define SHSF_CTL_CPOL      4
`define SHSF_CTL_FREEZE    5
`define SHSF_CTL_STOPST    6
`define SHSF_CTL_TXREQ     7
`define SHSF_CTL_RXREQ     8
`define SHSF_CTL_DIVHI     15
`define SHSF_CTL_DIVLO     9
`define SHSF_CTL_RESET     16'h0000
// Status register bit positions
`define SHSF_ST_TUE        14
`define SHSF_ST_TDE        15
`define SHSF_ST_RNE        17
`define SHSF_ST_RFF        19
`define SHSF_ST_ROE        20
`define SHSF_ST_BER        21
`define SHSF_ST_BUSY       22
// Interrupt vector codes
`define SHSF_VEC_NONE      3'h0
`define SHSF_VEC_TXDATA    3'h1
`define SHSF_VEC_TXUNDER   3'h2
`define SHSF_VEC_RXDATA    3'h3
`define SHSF_VEC_RXOVER    3'h4
// Link sizes
`define SHSF_BITS_PER_WORD 5'h08
// SPI words are full width
`define SHSF_BITS_PER_SPI  5'h18
`endif

// >>> hw/shsf_sync.v
// Two-flip-flop synchroniser for asynchronous pin inputs.
// Assumes a free-running ref_clk_in and synchronous active-high reset.
`timescale 1ns/1ps
module shsf_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             ref_clk_in,
  input  wire             rst_in,
  // Asynchronous level in, synchronised level out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta; // First stage, read only by the second

  // Two stages in series
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      meta     <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // shsf_sync

// >>> hw/shsf_core.v
// Serial host port with status flags: SPI or I2C, master or slave.
// Assumes software on a plain strobe port and pins from another domain.
//
// Summary of operation
// - Underrun only in slave modes, in I2C only with freeze clear
// - Underrun when holding and shifter empty
// - I2C underrun at ACK fall, resend word
// - SPI underrun: first edge or select assertion
// - Transmit vector chooses underrun or data
// - Underrun cleared by status read, holding write
// - Empty set on holding-to-shifter transfer, in SPI master phase 0 at word end
// - Empty cleared on holding write, set on reset
// - Not-empty flag follows queue occupancy
// - Full flag follows queue full
// - Overrun on full queue, word discarded
// - No overrun in I2C master or freeze
// - Receive vector chooses overrun or data
// - Overrun cleared by status read then queue read
// - I2C master no-ack: error, stop, suspend
// - SPI master select low: error, suspend
// - Bus error cleared only by resets
// - I2C busy from start to stop
// - SPI busy from select or pending data
// - SPI master drives MOSI, SPI slave drives MISO
// - Unselected slave keeps MISO released
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "shsf_map.vh"
module shsf_core #(
  parameter DW     = 24,  // Data word width
  parameter QDEPTH = 3,   // Receive queue depth
  parameter QAW    = 2    // Queue pointer width
) (
  // Clock and reset
  input  wire          ref_clk_in,
  input  wire          rst_in,
  // Register port
  input  wire [3:0]    reg_addr_in,
  input  wire [23:0]   reg_wdata_in,
  input  wire          reg_wr_in,
  input  wire          reg_rd_in,
  output reg  [23:0]   reg_rdata_out,
  // Serial clock pin
  input  wire          sck_in,
  output reg           sck_out,
  output reg           sck_oe_out,
  // Master out / slave in data
  input  wire          mosi_in,
  output reg           mosi_out,
  output reg           mosi_oe_out,
  // Master in / slave out data, I2C data
  input  wire          miso_in,
  output reg           miso_out,
  output reg           miso_oe_out,
  // Slave select, active low
  input  wire          ss_n_in,
  // Vector of the pending request
  output reg  [2:0]    vector_out
);
  // Control register fields
  reg  [15:0]   ctrl;
  wire          en      = ctrl[`SHSF_CTL_ENABLE];
  wire          i2c     = ctrl[`SHSF_CTL_I2C];
  wire          mst     = ctrl[`SHSF_CTL_MASTER];
  wire          clock_phase_select    = ctrl[`SHSF_CTL_CLOCK_PHASE_SELECT];
  wire          cpol    = ctrl[`SHSF_CTL_CPOL];
  wire          freeze  = ctrl[`SHSF_CTL_FREEZE];
  wire          stopst  = ctrl[`SHSF_CTL_STOPST];
  wire [6:0]    div     = ctrl[`SHSF_CTL_DIVHI:`SHSF_CTL_DIVLO];
  // Individual reset: block disabled, Stop state or hard reset
  wire          clr     = rst_in | ~en | stopst;

  // Synchronised pins
  wire [3:0]    pins_s;
  shsf_sync #(.WIDTH(4), .INIT(4'hb)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   ({ss_n_in, miso_in, mosi_in, sck_in}),
    .sync_out   (pins_s)
  );
  wire          sck_s   = pins_s[0];
  wire          mosi_s  = pins_s[1];
  wire          miso_s  = pins_s[2];
  wire          ss_n_s  = pins_s[3];

  // Edge history of the sampled pins
  reg           sck_d;
  reg           sda_d;
  reg           ss_n_d;
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sck_d  <= 1'b1;
      sda_d  <= 1'b1;
      ss_n_d <= 1'b1;
    end
    else
    begin
      sck_d  <= sck_s;
      sda_d  <= miso_s;
      ss_n_d <= ss_n_s;
    end
  end
  wire          sel      = ~ss_n_s;                   // Slave selected
  wire          sel_rise = ss_n_d & ~ss_n_s;          // Select asserted
  wire          sel_fall = ~ss_n_d & ss_n_s;          // Select released
  wire          ext_lead = (sck_s ^ cpol) & ~(sck_d ^ cpol); // Leading edge
  wire          ext_trail= ~(sck_s ^ cpol) & (sck_d ^ cpol); // Trailing edge
  wire          scl_fall = sck_d & ~sck_s;
  wire          scl_rise = ~sck_d & sck_s;
  wire          i2c_start= i2c & sck_s & sck_d & sda_d & ~miso_s;
  wire          i2c_stop = i2c & sck_s & sck_d & ~sda_d & miso_s;

  // Data path state
  reg [DW-1:0]  tx_hold;      // Transmit holding register
  reg [DW-1:0]  shifter;      // Serial shift register
  reg [DW-1:0]  last_tx;      // Word last loaded, for resend
  reg [DW-1:0]  rxq [0:QDEPTH-1]; // Receive queue
  reg [QAW-1:0] wp;
  reg [QAW-1:0] rp;
  reg [QAW:0]   cnt;          // Queue occupancy
  reg [4:0]     bitn;         // Bits moved in current word
  reg           sh_full;      // Shifter holds a word to send
  reg           active;       // Word in progress
  reg           tde;          // Transmit empty flag
  reg           tue;          // Transmit underrun flag
  reg           roe;          // Receive overrun flag
  reg           ber;          // Bus error flag
  reg           busy_i2c;     // I2C bus busy
  reg           halt;         // Master transmission suspended
  reg           st_seen_tue;  // Status read saw underrun
  reg           st_seen_roe;  // Status read saw overrun
  reg           ack_phase;    // I2C acknowledge bit slot
  reg [6:0]     divcnt;       // Master clock divider
  reg           mclk;         // Master clock level (polarity-free)

  wire          rnf   = (cnt != {(QAW+1){1'b0}});
  wire          rff   = (cnt == QDEPTH[QAW:0]);
  wire          busy  = i2c ? busy_i2c : (mst ? (~tde | sh_full | active) : sel);
  wire          wr_tx = reg_wr_in & (reg_addr_in == `SHSF_ADDR_TXHOLD);
  wire          rd_rx = reg_rd_in & (reg_addr_in == `SHSF_ADDR_RXQUEUE) & rnf;
  wire          rd_st = reg_rd_in & (reg_addr_in == `SHSF_ADDR_STATUS);
  wire          can_under = ~mst & (~i2c | ~freeze);
  wire [QAW-1:0] wp_next = (wp == QDEPTH[QAW-1:0] - 1'b1) ? {QAW{1'b0}} : wp + 1'b1;
  wire [QAW-1:0] rp_next = (rp == QDEPTH[QAW-1:0] - 1'b1) ? {QAW{1'b0}} : rp + 1'b1;

  // Master tick generator: half-period strobes
  wire          mtick = (divcnt == div);
  always @(posedge ref_clk_in)
  begin
    if (clr | ~mst)
      divcnt <= 7'h00;
    else if (mtick)
      divcnt <= 7'h00;
    else
      divcnt <= divcnt + 7'h01;
  end

  // Events that drive shifting
  // Sample and launch by role
  wire          m_run    = mst & ~i2c & active;
  wire          m_lead   = m_run & mtick & ~mclk;
  wire          m_trail  = m_run & mtick & mclk;
  wire          s_lead   = ~mst & ~i2c & sel & ext_lead;
  wire          s_trail  = ~mst & ~i2c & sel & ext_trail;
  wire          smp      = clock_phase_select ? (m_trail | s_trail) : (m_lead | s_lead);
  wire          lch      = clock_phase_select ? (m_lead | s_lead) : (m_trail | s_trail);
  wire          i2c_smp  = i2c & scl_rise & busy_i2c & ~ack_phase;
  wire          i2c_ackf = i2c & scl_fall & ack_phase;
  wire          din      = i2c ? miso_s : (mst ? miso_s : mosi_s);
  // I2C moves bytes, SPI moves whole words
  wire [4:0]    wlen     = i2c ? `SHSF_BITS_PER_WORD : `SHSF_BITS_PER_SPI;
  wire          word_done= (bitn == wlen - 5'h01) & (smp | i2c_smp);
  // SPI word start for underrun check
  wire          spi_start= ~i2c & ~mst & ((clock_phase_select & ext_lead & sel & ~active) | (~clock_phase_select & sel_rise));

  // Main sequential process: flags, shifter, queue
  always @(posedge ref_clk_in)
  begin
    if (clr)
    begin
      tue <= 1'b0;
      tde <= 1'b1;
      roe <= 1'b0;
      ber <= 1'b0;
      busy_i2c <= 1'b0;
      halt <= 1'b0;
      sh_full <= 1'b0;
      active <= 1'b0;
      bitn <= 5'h00;
      wp <= {QAW{1'b0}};
      rp <= {QAW{1'b0}};
      cnt <= {(QAW+1){1'b0}};
      ack_phase <= 1'b0;
      mclk <= 1'b0;
      st_seen_tue <= 1'b0;
      st_seen_roe <= 1'b0;
      tx_hold <= {DW{1'b0}};
      shifter <= {DW{1'b0}};
      last_tx <= {DW{1'b0}};
    end
    else
    begin
      // Remember what a status read saw
      if (rd_st)
      begin
        st_seen_tue <= tue;
        st_seen_roe <= roe;
      end
      if (wr_tx)
      begin
        tx_hold <= reg_wdata_in;
        tde <= 1'b0;
        if (st_seen_tue)
        begin
          tue <= 1'b0;
          st_seen_tue <= 1'b0;
        end
      end
      if (~tde & ~sh_full & ~active & ~wr_tx)
      begin
        shifter <= tx_hold;
        last_tx <= tx_hold;
        sh_full <= 1'b1;
        if (~(mst & ~i2c & ~clock_phase_select))
          tde <= 1'b1;
      end
      // Master clock toggles while a word runs
      if (m_run & mtick)
        mclk <= ~mclk;
      if (mst & ~i2c & sh_full & ~active & ~halt)
      begin
        active <= 1'b1;
        bitn <= 5'h00;
      end
      // Slave word starts, check for underrun
      if (spi_start)
      begin
        active <= 1'b1;
        bitn <= 5'h00;
        if (~sh_full & tde & can_under)
          tue <= 1'b1;
      end
      // Shift in the sampled bit
      if (smp | i2c_smp)
      begin
        shifter <= {shifter[DW-2:0], din};
        bitn <= bitn + 5'h01;
      end
      // Word complete
      if (word_done)
      begin
        bitn <= 5'h00;
        active <= 1'b0;
        sh_full <= 1'b0;
        mclk <= 1'b0;
        // Master phase 0: empty after word
        if (mst & ~i2c & ~clock_phase_select & ~wr_tx)
          tde <= 1'b1;
        if (i2c)
          ack_phase <= 1'b1;
        if (rff & ~rd_rx)
        begin
          // No overrun in I2C master or freeze
          if (~(i2c & (mst | freeze)))
            roe <= 1'b1;
        end
        else
        begin
          rxq[wp] <= {shifter[DW-2:0], din};
          wp <= wp_next;
        end
      end
      if (i2c_ackf)
      begin
        ack_phase <= 1'b0;
        if (~sh_full & tde & can_under)
        begin
          tue <= 1'b1;
          shifter <= last_tx;
          sh_full <= 1'b1;
        end
        if (mst & miso_s)
        begin
          ber <= 1'b1;
          halt <= 1'b1;
          busy_i2c <= 1'b0;
        end
      end
      if (mst & ~i2c & sel)
      begin
        ber <= 1'b1;
        halt <= 1'b1;
      end
      // Slave word abandoned when select released
      if (~mst & ~i2c & sel_fall)
        active <= 1'b0;
      // I2C busy from start to stop
      if (i2c_start)
        busy_i2c <= 1'b1;
      else if (i2c_stop)
        busy_i2c <= 1'b0;
      if (rd_rx)
      begin
        rp <= rp_next;
        if (st_seen_roe)
        begin
          roe <= 1'b0;
          st_seen_roe <= 1'b0;
        end
      end
      if (word_done & ~(rff & ~rd_rx) & ~rd_rx)
        cnt <= cnt + 1'b1;
      else if (rd_rx & ~(word_done))
        cnt <= cnt - 1'b1;
    end
  end

  // Control register; status is read-only
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      ctrl <= `SHSF_CTL_RESET;
    else if (reg_wr_in & (reg_addr_in == `SHSF_ADDR_CTRL))
      ctrl <= reg_wdata_in[15:0];
  end

  // Status word assembly
  // Full flag from occupancy
  reg [23:0]    status;
  always @*
  begin
    status = 24'h000000;
    status[15:0] = ctrl;
    status[`SHSF_ST_TUE]  = tue;
    status[`SHSF_ST_TDE]  = tde;
    status[`SHSF_ST_RNE]  = rnf;
    status[`SHSF_ST_RFF]  = rff;
    status[`SHSF_ST_ROE]  = roe;
    status[`SHSF_ST_BER]  = ber;
    status[`SHSF_ST_BUSY] = busy;
  end

  // Vector selection for pending requests
  reg [2:0]     next_vector;
  always @*
  begin
    next_vector = `SHSF_VEC_NONE;
    if (ctrl[`SHSF_CTL_RXREQ] & (roe | rnf))
      next_vector = roe ? `SHSF_VEC_RXOVER : `SHSF_VEC_RXDATA;
    else if (ctrl[`SHSF_CTL_TXREQ] & (tue | tde))
      next_vector = tue ? `SHSF_VEC_TXUNDER : `SHSF_VEC_TXDATA;
  end

  // Read data, one cycle after the strobe
  // Writes to the status address never reach status flags
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= 24'h000000;
      vector_out    <= `SHSF_VEC_NONE;
    end
    else
    begin
      vector_out <= next_vector;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          `SHSF_ADDR_CTRL:    reg_rdata_out <= {8'h00, ctrl};
          `SHSF_ADDR_STATUS:  reg_rdata_out <= status;
          `SHSF_ADDR_TXHOLD:  reg_rdata_out <= tx_hold;
          `SHSF_ADDR_RXQUEUE: reg_rdata_out <= rnf ? rxq[rp] : 24'h000000;
          `SHSF_ADDR_VECTOR:  reg_rdata_out <= {21'h000000, next_vector};
          default:            reg_rdata_out <= 24'h000000;
        endcase
      end
      else
        reg_rdata_out <= 24'h000000;
    end
  end

  // Pin drivers
  // Role decides which data pin drives
  always @(posedge ref_clk_in)
  begin
    if (clr)
    begin
      sck_out <= 1'b0;
      sck_oe_out <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe_out <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end
    else
    begin
      // Follow the new clock level so the pin lines up with the data launch
      sck_out <= (mclk ^ (m_run & mtick)) ^ cpol;
      sck_oe_out <= mst & ~i2c;
      mosi_oe_out <= mst & ~i2c;
      if (mst & ~i2c & (lch | (~active & ~clock_phase_select)))
        mosi_out <= shifter[DW-1];
      miso_oe_out <= ~mst & ~i2c & sel;
      if (~mst & ~i2c & (lch | (~active & ~clock_phase_select)))
        miso_out <= shifter[DW-1];
    end
  end
endmodule // shsf_core

// >>> tb/shsf_core_properties.sv
// Checker for the status-flag block: register port answers and pin roles.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module shsf_core_properties (
  // Clock and reset
  input wire        ref_clk_in,
  input wire        rst_in,
  // Register port
  input wire [3:0]  reg_addr_in,
  input wire [23:0] reg_wdata_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [23:0] reg_rdata_out,
  // Pins
  input wire        sck_in,
  input wire        sck_out,
  input wire        sck_oe_out,
  input wire        mosi_in,
  input wire        mosi_out,
  input wire        mosi_oe_out,
  input wire        miso_in,
  input wire        miso_out,
  input wire        miso_oe_out,
  input wire        ss_n_in,
  // Vector
  input wire [2:0]  vector_out
);
  reg [23:0] ctl;                          // Shadow of the control register
  reg [2:0]  since_wr;                     // Cycles since a control write
  reg        mst_clean;                    // Master entered from disabled state
  reg        stat_d;                       // Status answer stands now
  reg        ber_seen;                     // Bus error already reported
  wire       settled = (since_wr == 3'h7); // Mode change has landed

  // Track control writes and reported bus errors
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ctl <= 24'h0;
      since_wr <= 3'h0;
      mst_clean <= 1'b1;
      stat_d <= 1'b0;
      ber_seen <= 1'b0;
    end
    else
    begin
      stat_d <= reg_rd_in && (reg_addr_in == 4'h1);
      if (reg_wr_in && (reg_addr_in == 4'h0))
      begin
        ctl <= reg_wdata_in;
        since_wr <= 3'h0;
        // Disable or stop resets the flags
        if (!reg_wdata_in[0] || reg_wdata_in[6])
        begin
          mst_clean <= 1'b1;
          ber_seen <= 1'b0;
        end
        else if (!reg_wdata_in[2])
          mst_clean <= 1'b0;
      end
      else
      begin
        if (since_wr != 3'h7)
          since_wr <= since_wr + 3'h1;
        if (stat_d && settled && reg_rdata_out[21])
          ber_seen <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence stat_rd;
    reg_rd_in && (reg_addr_in == 4'h1);
  endsequence
  sequence slave_sel;
    (ctl[0] && !ctl[6] && !ctl[1] && !ctl[2] && settled && !ss_n_in) [*6];
  endsequence
  sequence master_sel;
    (ctl[0] && !ctl[6] && !ctl[1] && ctl[2] && settled && !ss_n_in) [*8];
  endsequence

  miso_release_a: assert property (
    (!ctl[1] && !ctl[2] && settled && ss_n_in) [*5] |-> !miso_oe_out) else $error("miso driven while unselected");
  mosi_role_a: assert property (
    settled && !ctl[1] && !ctl[2] |-> !mosi_oe_out) else $error("slave drives mosi");
  sck_role_a: assert property (
    settled && !ctl[1] && !ctl[2] |-> !sck_oe_out) else $error("slave drives sck");
  tue_master_a: assert property (
    stat_rd ##0 (ctl[2] && mst_clean && settled) |=> !reg_rdata_out[14]) else $error("underrun in master");
  ber_sticky_a: assert property (
    stat_rd ##0 ber_seen |=> reg_rdata_out[21]) else $error("bus error lost");
  ber_set_a: assert property (
    master_sel ##1 stat_rd |=> reg_rdata_out[21]) else $error("bus error not set");
  busy_slave_a: assert property (
    slave_sel ##0 stat_rd |=> reg_rdata_out[22]) else $error("busy not set while selected");
  full_nonempty_a: assert property (
    stat_rd |=> !(reg_rdata_out[19] && !reg_rdata_out[17])) else $error("full without not-empty");
endmodule // shsf_core_properties

bind shsf_core shsf_core_properties u_props (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .sck_in(sck_in), .sck_out(sck_out), .sck_oe_out(sck_oe_out),
  .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out),
  .miso_in(miso_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
  .ss_n_in(ss_n_in), .vector_out(vector_out));

// >>> tb/shsf_spi_master_model.sv
// Behavioural SPI master, clock idle low, data out on the first edge.
// Assumes the bench raises go_in and holds it until done_out rises.
`timescale 1ns/1ps
module shsf_spi_master_model (
  // Control from the bench
  input  wire        go_in,
  input  wire [23:0] word_in,
  // Serial lines
  input  wire        miso_in,
  output reg         sck_out,
  output reg         mosi_out,
  output reg         ss_n_out,
  // Result
  output reg         done_out,
  output reg  [23:0] got_out
);
  integer i; // Bit index, MSB first

  initial
  begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    ss_n_out = 1'b1;
    done_out = 1'b0;
    got_out = 24'h0;
  end

  // One frame per request; clock stands still between frames
  always
  begin
    wait (go_in);
    #13 ss_n_out = 1'b0;
    #160;
    for (i = 23; i >= 0; i = i - 1)
    begin
      sck_out = 1'b1;
      mosi_out = word_in[i];
      #160 sck_out = 1'b0;
      // Late sample leaves room for the slave's pin synchroniser
      #150 got_out = {got_out[22:0], miso_in};
      #10;
    end
    ss_n_out = 1'b1;
    mosi_out = ~mosi_out;
    done_out = 1'b1;
    wait (!go_in);
    done_out = 1'b0;
  end
endmodule // shsf_spi_master_model

// >>> tb/serial_host_status_flags_tb_top.sv
// Bench for the status-flag block in SPI slave and SPI master modes.
// Assumes a 25 MHz clock and a behavioural SPI master on the pins.
`timescale 1ns/1ps
module serial_host_status_flags_tb_top;
  reg         clk = 1'b0;   // Core clock
  reg         rst = 1'b1;   // Reset
  reg  [3:0]  a = 4'h0;     // Register address
  reg  [23:0] wd = 24'h0;   // Write data
  reg         we = 1'b0;    // Write strobe
  reg         re = 1'b0;    // Read strobe
  reg         force_sel = 1'b0;
  reg         tog = 1'b0;   // Released-line pattern
  reg         go = 1'b0;
  reg  [23:0] pword = 24'h0;
  wire [23:0] rdat;
  wire        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_sck, p_mosi, p_ss_n, p_done;
  wire [2:0]  vec;
  wire [23:0] p_got;
  wire        miso_w = miso_oe ? miso_o : tog;
  integer     failures = 0;
  integer     num_checks = 0;
  integer     seed = 86;
  integer     k;
  integer     t;            // Bound of the master capture loop
  reg         sck_p;        // Serial clock seen one cycle earlier
  reg  [23:0] q;
  reg  [23:0] w [0:4];

  always #20 clk = ~clk;
  always @(posedge clk) tog <= ~tog;

  shsf_core #(.DW(24), .QDEPTH(3), .QAW(2)) dut (
    .ref_clk_in(clk), .rst_in(rst), .reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(we),
    .reg_rd_in(re), .reg_rdata_out(rdat), .sck_in(sck_oe ? sck_o : p_sck), .sck_out(sck_o),
    .sck_oe_out(sck_oe), .mosi_in(mosi_oe ? mosi_o : p_mosi), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_o), .miso_oe_out(miso_oe), .ss_n_in(p_ss_n & ~force_sel),
    .vector_out(vec));
  shsf_spi_master_model u_master (
    .go_in(go), .word_in(pword), .miso_in(miso_w), .sck_out(p_sck), .mosi_out(p_mosi),
    .ss_n_out(p_ss_n), .done_out(p_done), .got_out(p_got));

  // Status word with flags in their places
  function [23:0] fl(input tue, tde, rne, rff, roe, ber, busy);
    fl = {1'b0, busy, ber, roe, rff, 1'b0, rne, 1'b0, tde, tue, 14'h0};
  endfunction

  task chk(input [8*8:1] nm, input [23:0] e, input [23:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [3:0] ad, input [23:0] d);
    begin
      @(posedge clk);
      a <= ad;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
    end
  endtask
  task rd(input [3:0] ad);
    begin
      @(posedge clk);
      a <= ad;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 q = rdat;
    end
  endtask
  task stat(input [23:0] e);
    begin
      rd(4'h1);
      chk("status", e, q & 24'h7ac000);
    end
  endtask
  task vchk(input [2:0] e);
    begin
      repeat (4) @(posedge clk);
      #1 chk("vector", {21'h0, e}, {21'h0, vec});
    end
  endtask
  // One partner frame, optionally reading busy mid-frame
  task frame(input [23:0] d, input mid);
    integer n;
    begin
      @(posedge clk);
      pword <= d;
      go <= 1'b1;
      if (mid)
      begin
        repeat (40) @(posedge clk);
        rd(4'h1);
        chk("busy", 24'h1, {23'h0, q[22]});
      end
      n = 0;
      while (p_done !== 1'b1 && n < 3000)
      begin
        @(posedge clk);
        n = n + 1;
      end
      if (p_done !== 1'b1)
      begin
        failures = failures + 1;
        $display("MISMATCH frame expected done seen timeout");
        test_done;
      end
      go <= 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 5; k = k + 1)
      w[k] = $random(seed);
    // Slave SPI, clock phase 1, unmapped place first
    wr(4'h0, 24'h000009);
    wr(4'hf, 24'h5a5a5a);
    rd(4'hf);
    chk("unmapped", 24'h0, q);
    stat(fl(0, 1, 0, 0, 0, 0, 0));
    wr(4'h2, w[4]);
    frame(w[0], 1'b1);
    chk("miso", w[4], p_got);
    stat(fl(0, 1, 1, 0, 0, 0, 0));
    frame(w[1], 1'b0);
    frame(w[2], 1'b0);
    stat(fl(1, 1, 1, 1, 0, 0, 0));
    frame(w[3], 1'b0);
    wr(4'h1, 24'hffffff);
    stat(fl(1, 1, 1, 1, 1, 0, 0));
    $display("test underrun and overrun done");
    wr(4'h0, 24'h000089);
    vchk(3'h2);
    wr(4'h0, 24'h000109);
    vchk(3'h4);
    stat(fl(1, 1, 1, 1, 1, 0, 0));
    for (k = 0; k < 3; k = k + 1)
    begin
      rd(4'h3);
      chk("queue", w[k], q);
      if (k == 0)
        stat(fl(1, 1, 1, 0, 0, 0, 0));
      if (k == 0)
        vchk(3'h3);
    end
    stat(fl(1, 1, 0, 0, 0, 0, 0));
    rd(4'h3);
    chk("empty", 24'h0, q);
    wr(4'h2, w[1]);
    rd(4'h1);
    chk("under", 24'h0, q & 24'h004000);
    wr(4'h0, 24'h000000);
    stat(fl(0, 1, 0, 0, 0, 0, 0));
    $display("test clears done");
    // Master SPI with select driven low from outside
    wr(4'h0, 24'h000005);
    force_sel <= 1'b1;
    repeat (16) @(posedge clk);
    stat(fl(0, 1, 0, 0, 0, 1, 0));
    force_sel <= 1'b0;
    wr(4'h1, 24'h000000);
    repeat (4) @(posedge clk);
    stat(fl(0, 1, 0, 0, 0, 1, 0));
    wr(4'h0, 24'h000000);
    stat(fl(0, 1, 0, 0, 0, 0, 0));
    $display("test bus error done");
    // Master SPI transmit, clock phase 1, bits caught on the falling clock
    wr(4'h0, 24'h00000d);
    wr(4'h2, w[2]);
    q = 24'h0;
    k = 0;
    for (t = 0; t < 300 && k < 24; t = t + 1)
    begin
      sck_p = sck_o;
      @(posedge clk);
      #1;
      if (sck_p === 1'b1 && sck_o === 1'b0)
      begin
        q = {q[22:0], mosi_o};
        k = k + 1;
      end
    end
    if (k != 24)
    begin
      failures = failures + 1;
      $display("MISMATCH mosi expected 24 bits seen timeout");
      test_done;
    end
    chk("mosi", w[2], q);
    repeat (4) @(posedge clk);
    stat(fl(0, 1, 1, 0, 0, 0, 0));
    $display("test master transmit done");
    test_done;
  end
endmodule // serial_host_status_flags_tb_top
